// ==== core/alu_status_and_pointer_mode.sv ====
// alu status flags and indirect-pointer step modes, reachable over apb
// assumes a core that issues one operation per op_valid pulse
// and raises ptrN_access once per indirect access
//
// Notes on behaviour
// - bits 7-6: pointer one decrements on 00, increments on 01, holds on 1x.
// - bits 5-4: pointer zero decrements on 00, increments on 01, holds on 1x.
// - bit 3 set when a signed arithmetic result overflows seven-bit magnitude, else cleared.
// - bit 2 set when an arithmetic or logic result is zero.
// - bit 1 takes the carry out of bit 3 on additions.
// - bit 0 takes the carry out of bit 7 on additions.
// - subtraction adds the two's complement of the second operand.
// - rotate through carry loads carry with the bit shifted out.
// - op writing this register cannot overwrite the flags it computes.
// - overflow set when the signed result leaves -128..+127.
`timescale 1ns/1ps
`default_nettype none
`include "alu_status_defines.svh"

module alu_status_and_pointer_mode #(
    parameter int ADDR_W = 12
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // datapath requests
    input  wire logic                    op_valid,
    input  wire alu_status_pkg::alu_req_t op_req,
    output logic [7:0]                   result_q,
    output logic                         result_valid_q,
    // indirect pointers
    input  wire logic                    ptr0_access,
    input  wire logic                    ptr1_access,
    output alu_status_pkg::step_t        ptr0_step_q,
    output alu_status_pkg::step_t        ptr1_step_q
);

    // =================================================================
    // elaboration checks
    if (ADDR_W < 4) begin : g_addr_check
        $error("ADDR_W too narrow for the register map");
    end
    // flag merging below assumes the four flags fill bits 3..0
    if (`OV_BIT != 3 || `C_BIT != 0) begin : g_flag_check
        $error("flag fields do not fill bits 3..0");
    end
    // reset must leave the upper bit of both step-mode fields set
    if ((`STA_RESET & 8'hA0) != 8'hA0) begin : g_reset_check
        $error("reset value does not hold both pointers");
    end

    // =================================================================
    // helpers
    function automatic alu_status_pkg::sum_t add8(
        input logic [7:0] x,
        input logic [7:0] y,
        input logic       cin
    );
        logic [4:0]           lo;
        logic [8:0]           full;
        alu_status_pkg::sum_t s;
        lo     = {1'h0, x[3:0]} + {1'h0, y[3:0]} + {4'h0, cin};
        full   = {1'h0, x} + {1'h0, y} + {8'h00, cin};
        s.res  = full[7:0];
        s.c    = full[8];
        s.dc   = lo[4];
        // same-sign operands giving other-sign result leave -128..+127
        s.ov   = (x[7] == y[7]) && (full[7] != x[7]);
        return s;
    endfunction : add8

    // affected flags take computed values, the rest keep the base
    function automatic logic [3:0] merge_flags(
        input logic [3:0] mask,
        input logic [3:0] computed,
        input logic [3:0] base
    );
        return (mask & computed) | (~mask & base);
    endfunction : merge_flags

    // =================================================================
    // register state
    logic [7:0]           sta_q;
    logic [7:0]           sta_d;
    logic                 op_fire;
    logic                 wr_sta;
    logic                 rd_sta;
    logic                 rd_res;

    assign op_fire = op_valid;

    // =================================================================
    // apb front
    apb_reg_port #(
        .ADDR_W (ADDR_W)
    ) u_port (
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pready  (pready),
        .pslverr (pslverr),
        .wr_sta  (wr_sta),
        .rd_sta  (rd_sta),
        .rd_res  (rd_res)
    );

    // unmapped and refused reads return zero
    // plain mux: every source is already a flop, so no read-side register
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_sta) begin
            prdata = {24'h00_0000, sta_q};
        end else if (rd_res) begin
            prdata = {24'h00_0000, result_q};
        end
    end

    // =================================================================
    // datapath
    logic [7:0]           res;
    logic [3:0]           aff;
    logic [3:0]           newf;
    logic                 is_add;
    logic [7:0]           ax;
    logic [7:0]           ay;
    logic                 acin;
    alu_status_pkg::sum_t sum;

    // one adder serves every arithmetic op; logic ops and rotates bypass it
    // operand choice for the single adder
    always_comb begin
        is_add = 1'h1;
        ax     = op_req.a;
        ay     = op_req.b;
        acin   = 1'h0;
        case (op_req.op)
            alu_status_pkg::OP_ADD: begin
                acin = 1'h0;
            end
            alu_status_pkg::OP_ADDC: begin
                acin = sta_q[`C_BIT];
            end
            // a - b done as a + ~b + 1; carry out is then no-borrow
            alu_status_pkg::OP_SUB: begin
                ay   = ~op_req.b;
                acin = 1'h1;
            end
            alu_status_pkg::OP_SUBB: begin
                ay   = ~op_req.b;
                acin = sta_q[`C_BIT];
            end
            alu_status_pkg::OP_INC: begin
                ay   = 8'h01;
            end
            alu_status_pkg::OP_DEC: begin
                ay   = ~8'h01;
                acin = 1'h1;
            end
            default: begin
                is_add = 1'h0;
            end
        endcase
    end

    assign sum = add8(ax, ay, acin);

    // result and flag mask; newf is {ov, z, dc, c}
    always_comb begin
        res  = op_req.a;
        aff  = 4'h0;
        newf = sta_q[3:0];
        if (is_add) begin
            res  = sum.res;
            aff  = 4'hF;
            newf = {sum.ov, sum.res == 8'h00, sum.dc, sum.c};
        end else begin
            case (op_req.op)
                alu_status_pkg::OP_AND: begin
                    res = op_req.a & op_req.b;
                end
                alu_status_pkg::OP_IOR: begin
                    res = op_req.a | op_req.b;
                end
                alu_status_pkg::OP_XOR: begin
                    res = op_req.a ^ op_req.b;
                end
                alu_status_pkg::OP_COMP: begin
                    res = ~op_req.a;
                end
                alu_status_pkg::OP_CLR: begin
                    res = 8'h00;
                end
                alu_status_pkg::OP_RLC: begin
                    res = {op_req.a[6:0], sta_q[`C_BIT]};
                end
                alu_status_pkg::OP_RRC: begin
                    res = {sta_q[`C_BIT], op_req.a[7:1]};
                end
                default: begin
                    res = op_req.a;
                end
            endcase
            case (op_req.op)
                alu_status_pkg::OP_AND,
                alu_status_pkg::OP_IOR,
                alu_status_pkg::OP_XOR,
                alu_status_pkg::OP_COMP,
                alu_status_pkg::OP_CLR: begin
                    aff[`Z_BIT]  = 1'h1;
                    newf[`Z_BIT] = res == 8'h00;
                end
                alu_status_pkg::OP_RLC: begin
                    aff[`C_BIT]  = 1'h1;
                    newf[`C_BIT] = op_req.a[7];
                end
                alu_status_pkg::OP_RRC: begin
                    aff[`C_BIT]  = 1'h1;
                    newf[`C_BIT] = op_req.a[0];
                end
                default: begin
                    aff = 4'h0;
                end
            endcase
        end
    end

    // =================================================================
    // status register next value
    // op flags win over a same-cycle apb write: hardware set beats software
    // an apb write in the same cycle as a to_status op is dropped
    always_comb begin
        sta_d = sta_q;
        if (op_fire && op_req.to_status) begin
            if (aff == 4'h0) begin
                sta_d = res;
            end else begin
                // written flag bits are blocked; mode bits take the result
                sta_d = {res[7:4], merge_flags(aff, newf, sta_q[3:0])};
            end
        end else begin
            if (wr_sta) begin
                sta_d = pwdata[7:0];
            end
            if (op_fire) begin
                sta_d[3:0] = merge_flags(aff, newf, sta_d[3:0]);
            end
        end
    end

    // flags get zero at reset only because a constant is needed
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sta_q <= `STA_RESET;
        end else begin
            sta_q <= sta_d;
        end
    end

    // =================================================================
    // result register
    // result_q holds between ops, so a late bus read still sees the last one
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_q       <= 8'h00;
            result_valid_q <= 1'h0;
        end else begin
            result_valid_q <= op_fire;
            if (op_fire) begin
                result_q <= res;
            end
        end
    end

    // =================================================================
    // pointer step control
    // mode is taken as the register stands at the access edge; a write
    // landing on that same edge only applies from the next access
    pointer_step_unit u_step1 (
        .clk    (clk),
        .reset  (reset),
        .mode   (sta_q[`PTR1_MODE_HI:`PTR1_MODE_LO]),
        .access (ptr1_access),
        .step_q (ptr1_step_q)
    );

    pointer_step_unit u_step0 (
        .clk    (clk),
        .reset  (reset),
        .mode   (sta_q[`PTR0_MODE_HI:`PTR0_MODE_LO]),
        .access (ptr0_access),
        .step_q (ptr0_step_q)
    );

endmodule : alu_status_and_pointer_mode
`default_nettype wire

// ==== core/alu_status_defines.svh ====
// offsets, field positions and reset value of the alu status register block
// assumes byte addressing on a 32-bit apb, one register per aligned word
`ifndef ALU_STATUS_DEFINES_SVH
`define ALU_STATUS_DEFINES_SVH

// =====================================================================
// register offsets (byte addresses)
`define STA_OFFSET      12'h004
`define RESULT_OFFSET   12'h008

// =====================================================================
// field positions of the status register
`define PTR1_MODE_HI    7
`define PTR1_MODE_LO    6
`define PTR0_MODE_HI    5
`define PTR0_MODE_LO    4
`define OV_BIT          3
`define Z_BIT           2
`define DC_BIT          1
`define C_BIT           0

// =====================================================================
// reset value and step-mode encodings
`define STA_RESET       8'hF0
`define MODE_DEC        2'h0
`define MODE_INC        2'h1

`endif

// ==== core/alu_status_pkg.sv ====
// types shared by the alu status block and its helpers
// assumes nothing of its surroundings
package alu_status_pkg;

    // =================================================================
    // operations of the 8-bit datapath
    typedef enum logic [3:0] {
        OP_MOV  = 4'h0,
        OP_ADD  = 4'h1,
        OP_ADDC = 4'h2,
        OP_SUB  = 4'h3,
        OP_SUBB = 4'h4,
        OP_INC  = 4'h5,
        OP_DEC  = 4'h6,
        OP_AND  = 4'h7,
        OP_IOR  = 4'h8,
        OP_XOR  = 4'h9,
        OP_COMP = 4'hA,
        OP_RLC  = 4'hB,
        OP_RRC  = 4'hC,
        OP_CLR  = 4'hD
    } alu_op_t;

    // =================================================================
    // carriers
    typedef struct packed {
        alu_op_t    op;
        logic [7:0] a;
        logic [7:0] b;
        logic       to_status;
    } alu_req_t;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       dc;
        logic       ov;
    } sum_t;

    typedef struct packed {
        logic inc;
        logic dec;
    } step_t;

endpackage : alu_status_pkg

// ==== core/apb_reg_port.sv ====
// apb slave front: decodes the two registers and answers every transfer
// assumes a zero-wait slave; pready is held high
`timescale 1ns/1ps
`default_nettype none
`include "alu_status_defines.svh"

module apb_reg_port #(
    parameter int ADDR_W = 12
) (
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   wr_sta,
    output logic                   rd_sta,
    output logic                   rd_res
);

    logic access;
    logic hit_sta;
    logic hit_res;

    assign access  = psel & penable;
    assign hit_sta = paddr == ADDR_W'(`STA_OFFSET);
    assign hit_res = paddr == ADDR_W'(`RESULT_OFFSET);
    assign pready  = 1'h1;
    // result word is read-only: a write to it is refused with an error
    assign pslverr = access & ~(hit_sta | (hit_res & ~pwrite));
    assign wr_sta  = access & pwrite & hit_sta;
    assign rd_sta  = hit_sta & ~pwrite;
    assign rd_res  = hit_res & ~pwrite;

endmodule : apb_reg_port
`default_nettype wire

// ==== core/pointer_step_unit.sv ====
// turns a pointer step-mode field and an access pulse into step pulses
// assumes access is a one-cycle pulse from the indirect-access logic
`timescale 1ns/1ps
`default_nettype none
`include "alu_status_defines.svh"

module pointer_step_unit (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic [1:0]           mode,
    input  wire logic                 access,
    output alu_status_pkg::step_t     step_q
);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            step_q <= '0;
        end else begin
            // upper mode bit set: pointer holds
            step_q.dec <= access & (mode == `MODE_DEC);
            step_q.inc <= access & (mode == `MODE_INC);
        end
    end

endmodule : pointer_step_unit
`default_nettype wire

// ==== verification/alu_status_monitor.sv ====
// port assertions for the alu status block
// assumes a bind into alu_status_and_pointer_mode
`timescale 1ns/1ps
`default_nettype none
`include "alu_status_defines.svh"
module alu_status_monitor #(
    parameter int ADDR_W = 12
) (
    input wire logic                     clk,
    input wire logic                     reset,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [ADDR_W-1:0]        paddr,
    input wire logic [31:0]              prdata,
    input wire logic                     pslverr,
    input wire logic                     op_valid,
    input wire alu_status_pkg::alu_req_t op_req,
    input wire logic [7:0]               result_q,
    input wire logic                     result_valid_q,
    input wire logic                     ptr0_access,
    input wire logic                     ptr1_access,
    input wire alu_status_pkg::step_t    ptr0_step_q,
    input wire alu_status_pkg::step_t    ptr1_step_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // ====
    // bus
    logic acc;
    logic mapped;
    assign acc = psel && penable;
    assign mapped = paddr == `STA_OFFSET || paddr == `RESULT_OFFSET;
    a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_result_ro: assert property (acc && pwrite && paddr == `RESULT_OFFSET |-> pslverr)
        else $error("result write not refused");
    // ====
    // datapath
    a_valid_pulse: assert property (op_valid |=> result_valid_q)
        else $error("no result strobe");
    a_add_result: assert property (op_valid && !op_req.to_status && op_req.op == alu_status_pkg::OP_ADD
        |=> result_q == $past(op_req.a + op_req.b)) else $error("bad sum");
    a_sub_result: assert property (op_valid && !op_req.to_status && op_req.op == alu_status_pkg::OP_SUB
        |=> result_q == $past(op_req.a + ~op_req.b + 8'h01)) else $error("bad difference");
    // ====
    // pointer steps
    a_step0_idle: assert property (!ptr0_access |=> ptr0_step_q == 2'h0)
        else $error("pointer zero stepped unasked");
    a_step1_idle: assert property (!ptr1_access |=> ptr1_step_q == 2'h0)
        else $error("pointer one stepped unasked");
    a_step_onehot: assert property (!(ptr0_step_q.inc && ptr0_step_q.dec)
        && !(ptr1_step_q.inc && ptr1_step_q.dec)) else $error("step both ways");
    cover property (op_valid && op_req.op == alu_status_pkg::OP_SUB);
    cover property (ptr1_step_q.inc);
    cover property (acc && pslverr);
endmodule : alu_status_monitor
bind alu_status_and_pointer_mode alu_status_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .op_valid(op_valid),
    .op_req(op_req), .result_q(result_q), .result_valid_q(result_valid_q),
    .ptr0_access(ptr0_access), .ptr1_access(ptr1_access),
    .ptr0_step_q(ptr0_step_q), .ptr1_step_q(ptr1_step_q)
);
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the alu status block
// assumes the design package and defines are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "alu_status_defines.svh"
module tb;
    logic                     clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]              paddr;
    logic [31:0]              pwdata, prdata, rd;
    logic                     op_valid, result_valid_q, ptr0_access, ptr1_access;
    alu_status_pkg::alu_req_t op_req;
    logic [7:0]               result_q;
    alu_status_pkg::step_t    ptr0_step_q, ptr1_step_q;
    int                       num_errors, check_count;
    alu_status_and_pointer_mode #(.ADDR_W(12)) u_alu_status_and_pointer_mode (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_valid(op_valid), .op_req(op_req), .result_q(result_q),
        .result_valid_q(result_valid_q), .ptr0_access(ptr0_access),
        .ptr1_access(ptr1_access), .ptr0_step_q(ptr0_step_q), .ptr1_step_q(ptr1_step_q));
    // ====
    // helpers
    task final_report;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // bounded wait: a slave that never answers ends the run
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            num_errors++;
            final_report();
        end
    endtask : apb
    task op(input alu_status_pkg::alu_op_t o, input logic [7:0] a, b, input logic ts);
        @(posedge clk);
        op_valid <= 1'b1;
        op_req <= '{o, a, b, ts};
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk("result strobe", 1'b1, result_valid_q);
    endtask : op
    task pulse_ptrs;
        @(posedge clk);
        ptr0_access <= 1'b1;
        ptr1_access <= 1'b1;
        @(posedge clk);
        ptr0_access <= 1'b0;
        ptr1_access <= 1'b0;
        #1;
    endtask : pulse_ptrs
    // {ov, z, dc, c} of a + b + ci
    function automatic logic [3:0] addf(input logic [7:0] a, b, input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = a + b + ci;
        h = a[3:0] + b[3:0] + ci;
        addf = {a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00, h[4], s[8]};
    endfunction : addf
    function automatic logic [1:0] sexp(input logic [1:0] m);
        sexp = m == 2'h0 ? 2'h1 : (m == 2'h1 ? 2'h2 : 2'h0);
    endfunction : sexp
    // ====
    // scenarios
    task t_reset;
        apb(1'b0, `STA_OFFSET, 32'h0);
        chk("reset modes", 4'hF, rd[7:4]);
        pulse_ptrs();
        chk("reset steps", 4'h0, {ptr1_step_q, ptr0_step_q});
        $display("test reset done");
    endtask : t_reset
    task t_modes;
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            apb(1'b1, `STA_OFFSET, {24'h00_0000, m, ~m, 4'h0});
            pulse_ptrs();
            chk("ptr1 step", sexp(m), ptr1_step_q);
            chk("ptr0 step", sexp(~m), ptr0_step_q);
        end
        $display("test modes done");
    endtask : t_modes
    task t_flags;
        logic [7:0] a, b;
        logic [15:0] pr [7];
        pr = '{16'h7F01, 16'hFF01, 16'h8080, 16'h0F01, 16'h0503, 16'h0305, 16'h8001};
        for (int i = 0; i < 7; i++) begin
            {a, b} = pr[i];
            op(alu_status_pkg::OP_ADD, a, b, 1'b0);
            chk("add result", 8'(a + b), result_q);
            apb(1'b0, `STA_OFFSET, 32'h0);
            chk("add flags", addf(a, b, 1'b0), rd[3:0]);
            op(alu_status_pkg::OP_SUB, a, b, 1'b0);
            chk("sub result", 8'(a - b), result_q);
            apb(1'b0, `STA_OFFSET, 32'h0);
            chk("sub flags", addf(a, ~b, 1'b1), rd[3:0]);
        end
        $display("test flags done");
    endtask : t_flags
    task t_rot;
        logic [7:0] src [4];
        logic [7:0] res [4];
        logic cy [4];
        src = '{8'h00, 8'h80, 8'h01, 8'h02};
        res = '{8'h01, 8'h00, 8'h80, 8'h81};
        cy = '{1'b0, 1'b1, 1'b1, 1'b0};
        op(alu_status_pkg::OP_ADD, 8'hFF, 8'h01, 1'b0);
        for (int i = 0; i < 4; i++) begin
            op(i < 2 ? alu_status_pkg::OP_RLC : alu_status_pkg::OP_RRC, src[i], 8'h00, 1'b0);
            chk("rotate result", res[i], result_q);
            apb(1'b0, `STA_OFFSET, 32'h0);
            chk("rotate carry", cy[i], rd[0]);
        end
        $display("test rotate done");
    endtask : t_rot
    // rows: {op, a, b, result, flags ov z dc c}, flags worked out by hand
    task t_ops;
        logic [31:0] rows [10];
        rows = '{32'h1FF0_1007, 32'h2102_0310, 32'h4502_02F1, 32'h5FF0_0007, 32'h6000_0FF0,
                 32'h7F00_F004, 32'h8500_A5A0, 32'hAFF0_0004, 32'h0A50_0A54, 32'h93C3_D010};
        for (int i = 0; i < 10; i++) begin
            op(alu_status_pkg::alu_op_t'(rows[i][31:28]), rows[i][27:20], rows[i][19:12], 1'b0);
            chk("op result", rows[i][11:4], result_q);
            apb(1'b0, `STA_OFFSET, 32'h0);
            chk("op flags", rows[i][3:0], rd[3:0]);
        end
        $display("test remaining ops done");
    endtask : t_ops
    task t_dest;
        apb(1'b1, `STA_OFFSET, 32'h0000_003A);
        chk("status write err", 1'b0, err);
        op(alu_status_pkg::OP_ADD, 8'hFF, 8'h01, 1'b1);
        apb(1'b0, `STA_OFFSET, 32'h0);
        chk("add into status", 32'h0000_0007, rd);
        apb(1'b1, `STA_OFFSET, 32'h0000_003B);
        op(alu_status_pkg::OP_CLR, 8'h00, 8'h00, 1'b1);
        apb(1'b0, `STA_OFFSET, 32'h0);
        chk("clear into status", 32'h0000_000F, rd);
        $display("test destination done");
    endtask : t_dest
    task t_err;
        op(alu_status_pkg::OP_ADD, 8'h12, 8'h34, 1'b0);
        apb(1'b1, `RESULT_OFFSET, 32'h0000_00FF);
        chk("result write err", 1'b1, err);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 1'b1, err);
        chk("unmapped data", 32'h0, rd);
        apb(1'b0, `RESULT_OFFSET, 32'h0);
        chk("result read", 32'h0000_0046, rd);
        chk("result err", 1'b0, err);
        $display("test refusals done");
    endtask : t_err
    // ====
    // run
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {reset, psel, penable, pwrite, op_valid, ptr0_access, ptr1_access} = 7'h7F & 7'h40;
        {paddr, pwdata, op_req} = '0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_modes();
        t_flags();
        t_rot();
        t_ops();
        t_dest();
        t_err();
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        t_reset();
        final_report();
    end
endmodule : tb
`default_nettype wire
